// >>> hdl/smf_pkg.sv
// Shared constants and types for the shunt result formatter and mode block.
package smf_pkg;

	localparam int unsigned SMF_CLK_NS = 50;
	localparam int unsigned SMF_CYC_W  = 21;
	typedef logic [SMF_CYC_W-1:0] smf_cyc_t;
	typedef logic [15:0][SMF_CYC_W-1:0] smf_cyc_tab_t;

	// Conversion times in microseconds times one hundred.
	localparam int unsigned SMF_T_9B   = 8400;
	localparam int unsigned SMF_T_10B  = 14800;
	localparam int unsigned SMF_T_11B  = 27600;
	localparam int unsigned SMF_T_12B  = 53200;
	localparam int unsigned SMF_T_AV2  = 106000;
	localparam int unsigned SMF_T_AV4  = 213000;
	localparam int unsigned SMF_T_AV8  = 426000;
	localparam int unsigned SMF_T_AV16 = 851000;
	localparam int unsigned SMF_T_AV32 = 1702000;
	localparam int unsigned SMF_T_AV64 = 3405000;
	localparam int unsigned SMF_T_AV128 = 6810000;

	typedef struct packed {
		logic       rst_bit;
		logic       rsvd;
		logic       bus_range;
		logic [1:0] gain_select;
		logic [3:0] bus_conv_setting;
		logic [3:0] shunt_conv_setting;
		logic [2:0] op_select;
	} smf_cfg_t;

	localparam logic [15:0] SMF_CFG_RST    = 16'h399f;
	localparam logic [7:0]  SMF_CFG_PTR    = 8'h00;
	localparam logic [7:0]  SMF_SHUNT_PTR  = 8'h01;

	localparam logic [2:0] SMF_OP_PWRDN  = 3'h0;
	localparam logic [2:0] SMF_OP_OFF    = 3'h4;
	localparam int unsigned SMF_OP_SH_B  = 0;
	localparam int unsigned SMF_OP_BUS_B = 1;
	localparam int unsigned SMF_OP_CONT_B = 2;

	localparam logic [16:0] SMF_FS_UNITY = 17'h00fa0;
	localparam int unsigned SMF_SGN_MAX  = 4;

	typedef enum logic [1:0] {
		SMF_IDLE  = 2'b00,
		SMF_SHUNT = 2'b01,
		SMF_BUS   = 2'b10
	} smf_phase_t;

	function automatic smf_cyc_t smf_cyc(input int unsigned t_cus);
		return smf_cyc_t'((t_cus * 10 + SMF_CLK_NS - 1) / SMF_CLK_NS);
	endfunction

	function automatic smf_cyc_tab_t smf_default_tab();
		smf_cyc_tab_t t;
		for (int i = 0; i < 16; i++)
		begin
			case (i[3:0])
				4'h0, 4'h4:  t[i] = smf_cyc(SMF_T_9B);
				4'h1, 4'h5:  t[i] = smf_cyc(SMF_T_10B);
				4'h2, 4'h6:  t[i] = smf_cyc(SMF_T_11B);
				4'h9:        t[i] = smf_cyc(SMF_T_AV2);
				4'ha:        t[i] = smf_cyc(SMF_T_AV4);
				4'hb:        t[i] = smf_cyc(SMF_T_AV8);
				4'hc:        t[i] = smf_cyc(SMF_T_AV16);
				4'hd:        t[i] = smf_cyc(SMF_T_AV32);
				4'he:        t[i] = smf_cyc(SMF_T_AV64);
				4'hf:        t[i] = smf_cyc(SMF_T_AV128);
				default:     t[i] = smf_cyc(SMF_T_12B);
			endcase
		end
		return t;
	endfunction

	localparam smf_cyc_tab_t SMF_CONV_CYC = smf_default_tab();

	typedef struct packed {
		smf_cfg_t    cfg;
		smf_phase_t  phase;
		smf_cyc_t    cnt;
		logic [15:0] result;
		logic        ready;
	} smf_state_t;

endpackage

// >>> hdl/smf_fmt.sv
// Saturating shunt code formatter for the selected gain range.
`timescale 1ns/100ps
`default_nettype none
module smf_fmt
	import smf_pkg::*;
(
	input  wire logic [16:0] sample_i,
	input  wire logic [1:0]  gain_i,
	output logic      [15:0] code_o
);
	logic signed [16:0] fs_pos;
	logic signed [16:0] fs_neg;
	logic signed [16:0] smp;
	logic signed [16:0] sat;

	always_comb
	begin
		fs_pos = $signed(SMF_FS_UNITY << gain_i);
		fs_neg = -fs_pos;
		smp    = $signed(sample_i);
		if (smp > fs_pos)
			sat = fs_pos;
		else if (smp < fs_neg)
			sat = fs_neg;
		else
			sat = smp;
		code_o = sat[15:0];
	end
endmodule
`default_nettype wire

// >>> hdl/smf_core.sv
// Operating mode sequencer and shunt result register.
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// - Settings 1101, 1110, 1111 average 32, 64, 128 samples, 17.02/34.05/68.10 ms.
// - A 3-bit mode field in config bits 0 to 2 selects the operation.
// - After reset the mode is continuous shunt and bus conversion.
// - Mode 000 off, 001-011 triggered, 100 disabled, 101-111 continuous.
// - Shunt result is aligned per gain range with all sign bits equal.
// - Negative readings are two's complement, sign extended above magnitude.
// - Divide-by-8 range is 10 uV steps, codes 7D00h and 8300h.
// - Divide-by-4 range is 10 uV steps, positive full scale 3E80h.
// - Divide-by-2 range is 10 uV steps, codes 1F40h and E0C0h.
// - Unity range is 10 uV steps, codes 0FA0h and F060h.
// - One to four sign bits as range narrows from widest to unity.
// - Readings beyond full scale saturate at full scale, never wrap.
// - Gain field codes 00 to 11 select 40 to 320 mV, default 320.
// - Lower settings pick 9 to 12 bits or 2 to 16 sample averages.
// - Writing an active mode clears the conversion ready flag, but a sequence that ends in the same cycle sets it.
module smf_core
	import smf_pkg::*;
#(
	parameter smf_cyc_tab_t CONV_CYC = SMF_CONV_CYC
)
(
	input  wire logic        mclk_i,
	input  wire logic        srst_i,
	input  wire logic        cfg_wr_i,
	input  wire logic [15:0] cfg_wdata_i,
	input  wire logic        bus_rd_i,
	input  wire logic [16:0] shunt_sample_i,
	output logic      [15:0] cfg_o,
	output logic      [15:0] shunt_drop_result_o,
	output logic             conversion_ready_flag_o,
	output logic             shunt_conv_active_o,
	output logic             bus_conv_active_o,
	output logic             shunt_sample_take_o
);
	smf_state_t  st_r;
	smf_state_t  st_nxt;
	smf_cfg_t    wcfg;
	logic [15:0] fmt_code;
	logic        phase_end;
	logic        seq_done;
	logic        mode_active;

	localparam smf_cfg_t RST_CFG = smf_cfg_t'(SMF_CFG_RST);

	smf_fmt u_fmt (
		.sample_i (shunt_sample_i),
		.gain_i   (st_r.cfg.gain_select),
		.code_o   (fmt_code)
	);

	always_comb
	begin
		st_nxt    = st_r;
		wcfg      = cfg_wr_i ? smf_cfg_t'(cfg_wdata_i) : st_r.cfg;
		if (wcfg.rst_bit)
			wcfg = smf_cfg_t'(SMF_CFG_RST);
		wcfg.rst_bit = 1'b0;
		mode_active = wcfg.op_select != SMF_OP_PWRDN &&
			wcfg.op_select != SMF_OP_OFF;
		phase_end = st_r.phase != SMF_IDLE && st_r.cnt == smf_cyc_t'(1);
		seq_done  = 1'b0;
		shunt_sample_take_o = 1'b0;
		if (st_r.phase != SMF_IDLE && !phase_end)
			st_nxt.cnt = st_r.cnt - smf_cyc_t'(1);
		if (phase_end && st_r.phase == SMF_SHUNT)
		begin
			shunt_sample_take_o = 1'b1;
			st_nxt.result = fmt_code;
			if (st_r.cfg.op_select[SMF_OP_BUS_B])
			begin
				st_nxt.phase = SMF_BUS;
				st_nxt.cnt   = CONV_CYC[st_r.cfg.bus_conv_setting];
			end
			else
				seq_done = 1'b1;
		end
		if (phase_end && st_r.phase == SMF_BUS)
			seq_done = 1'b1;
		if (seq_done)
		begin
			if (st_r.cfg.op_select[SMF_OP_CONT_B])
			begin
				st_nxt.phase = st_r.cfg.op_select[SMF_OP_SH_B] ?
					SMF_SHUNT : SMF_BUS;
				st_nxt.cnt = st_r.cfg.op_select[SMF_OP_SH_B] ?
					CONV_CYC[st_r.cfg.shunt_conv_setting] :
					CONV_CYC[st_r.cfg.bus_conv_setting];
			end
			else
				st_nxt.phase = SMF_IDLE;
		end
		if (bus_rd_i)
			st_nxt.ready = 1'b0;
		if (cfg_wr_i)
		begin
			st_nxt.cfg = wcfg;
			if (mode_active)
				st_nxt.ready = 1'b0;
			case (wcfg.op_select)
				3'h1, 3'h3, 3'h5, 3'h7:
				begin
					st_nxt.phase = SMF_SHUNT;
					st_nxt.cnt   = CONV_CYC[wcfg.shunt_conv_setting];
				end
				3'h2, 3'h6:
				begin
					st_nxt.phase = SMF_BUS;
					st_nxt.cnt   = CONV_CYC[wcfg.bus_conv_setting];
				end
				default:
					st_nxt.phase = SMF_IDLE;
			endcase
		end
		if (seq_done)
			st_nxt.ready = 1'b1;
	end

	always_ff @(posedge mclk_i)
	begin
		if (srst_i)
		begin
			st_r.cfg    <= smf_cfg_t'(SMF_CFG_RST);
			st_r.phase  <= SMF_SHUNT;
			st_r.cnt    <= CONV_CYC[RST_CFG.shunt_conv_setting];
			st_r.result <= 16'h0000;
			st_r.ready  <= 1'b0;
		end
		else
			st_r <= st_nxt;
	end

	assign cfg_o                   = st_r.cfg;
	assign shunt_drop_result_o     = st_r.result;
	assign conversion_ready_flag_o = st_r.ready;
	assign shunt_conv_active_o     = st_r.phase == SMF_SHUNT;
	assign bus_conv_active_o       = st_r.phase == SMF_BUS;

	// Checking helpers.
	logic signed [16:0] chk_fs;
	logic [SMF_SGN_MAX-1:0] chk_sgn;
	logic               chk_sgn_ok;
	logic               chk_in_rng;

	always_comb
	begin
		chk_fs     = $signed(SMF_FS_UNITY << st_r.cfg.gain_select);
		chk_sgn    = st_r.result[15 -: SMF_SGN_MAX];
		chk_sgn_ok = 1'b1;
		for (int i = 0; i < SMF_SGN_MAX; i++)
			if (i < SMF_SGN_MAX - int'(st_r.cfg.gain_select) &&
				chk_sgn[SMF_SGN_MAX-1-i] != st_r.result[15])
				chk_sgn_ok = 1'b0;
		chk_in_rng = $signed(shunt_sample_i) <= chk_fs &&
			$signed(shunt_sample_i) >= -chk_fs;
	end

	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (srst_i);

	property p_rst_cfg;
		$fell(srst_i) |-> cfg_o == SMF_CFG_RST && bus_conv_active_o == 1'b0;
	endproperty
	a_rst_cfg: assert property (p_rst_cfg) else $error("reset config wrong");

	property p_off_idle;
		(cfg_wr_i && (cfg_wdata_i[2:0] == SMF_OP_PWRDN ||
			cfg_wdata_i[2:0] == SMF_OP_OFF) && !cfg_wdata_i[15])
			##1 !cfg_wr_i [*3] |-> !shunt_conv_active_o && !bus_conv_active_o;
	endproperty
	a_off_idle: assert property (p_off_idle) else $error("conversion while off");

	property p_ready_clr;
		cfg_wr_i && cfg_wdata_i[1:0] != 2'b00 && !seq_done |=>
			!conversion_ready_flag_o;
	endproperty
	a_ready_clr: assert property (p_ready_clr) else $error("ready not cleared");

	property p_sat;
		shunt_sample_take_o |=>
			$signed(shunt_drop_result_o) <= $past(chk_fs) &&
			$signed(shunt_drop_result_o) >= -$past(chk_fs);
	endproperty
	a_sat: assert property (p_sat) else $error("result beyond full scale");

	property p_sign;
		$rose(shunt_sample_take_o) |=> chk_sgn_ok;
	endproperty
	a_sign: assert property (p_sign) else $error("sign bits differ");

	property p_exact;
		shunt_sample_take_o && chk_in_rng && !cfg_wr_i |=>
			shunt_drop_result_o == $past(shunt_sample_i[15:0]);
	endproperty
	a_exact: assert property (p_exact) else $error("in range code wrong");

	property p_trig_idle;
		seq_done && !cfg_wr_i && !st_r.cfg.op_select[SMF_OP_CONT_B] |=>
			!shunt_conv_active_o && !bus_conv_active_o ##1
			($past(cfg_wr_i) ||
			(!shunt_conv_active_o && !bus_conv_active_o));
	endproperty
	a_trig_idle: assert property (p_trig_idle) else $error("trigger reran");

	property p_conv_len;
		!shunt_conv_active_o ##1 shunt_conv_active_o |->
			st_r.cnt == CONV_CYC[st_r.cfg.shunt_conv_setting];
	endproperty
	a_conv_len: assert property (p_conv_len) else $error("bad time");

	property p_mode_start;
		cfg_wr_i && cfg_wdata_i[0] && !cfg_wdata_i[15] && !seq_done |=>
			shunt_conv_active_o && conversion_ready_flag_o == 1'b0;
	endproperty
	a_mode_start: assert property (p_mode_start) else $error("no start");

	property p_cfg_store;
		cfg_wr_i && !cfg_wdata_i[15] |=> cfg_o == $past(cfg_wdata_i);
	endproperty
	a_cfg_store: assert property (p_cfg_store)
		else $error("config not stored");

	property p_rst_word;
		cfg_wr_i && cfg_wdata_i[15] |=> cfg_o == SMF_CFG_RST;
	endproperty
	a_rst_word: assert property (p_rst_word)
		else $error("reset bit ignored");

	property p_rst_run;
		$fell(srst_i) |-> shunt_conv_active_o && !conversion_ready_flag_o &&
			shunt_drop_result_o == 16'h0000;
	endproperty
	a_rst_run: assert property (p_rst_run)
		else $error("reset run wrong");
endmodule
`default_nettype wire

// >>> dv/smf_adc_model.sv
// Converter model that offers the shunt sample to the block.
`timescale 1ns/100ps
`default_nettype none
module smf_adc_model
(
	input  wire logic        take_i,
	input  wire logic [16:0] value_i,
	output logic      [16:0] sample_o
);
	// Off the take cycle the lines carry the inverse, so a stray capture shows.
	assign sample_o = take_i ? value_i : ~value_i;
endmodule
`default_nettype wire

// >>> dv/tb_top.sv
// Self-checking bench for the shunt result formatter and mode block.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	import smf_pkg::*;
	logic        mclk_i = 1'b0;
	logic        srst_i = 1'b1;
	logic        cfg_wr_i = 1'b0;
	logic [15:0] cfg_wdata_i = 16'h0000;
	logic        bus_rd_i = 1'b0;
	logic [16:0] val = 17'h00000;
	logic [16:0] smp_w;
	logic [15:0] cfg_w;
	logic [15:0] res;
	logic        rdy;
	logic        sh_act;
	logic        bus_act;
	logic        take;
	int          n_mismatch = 0;
	int          samples_checked = 0;
	localparam logic [15:0] POS [4] = '{16'h0fa0, 16'h1f40, 16'h3e80, 16'h7d00};
	localparam logic [15:0] NEG [4] = '{16'hf060, 16'he0c0, 16'hc180, 16'h8300};
	function automatic smf_cyc_tab_t mk_tab();
		smf_cyc_tab_t t;
		for (int i = 0; i < 16; i++)
			t[i] = smf_cyc_t'(i + 4);
		return t;
	endfunction
	localparam smf_cyc_tab_t TAB = mk_tab();
	function automatic logic [15:0] fmt(input logic [16:0] s, input int g);
		int fs;
		int v;
		fs = 4000 << g;
		v = $signed(s);
		v = (v > fs) ? fs : v;
		v = (v < -fs) ? -fs : v;
		return v[15:0];
	endfunction
	always #25 mclk_i = ~mclk_i;
	smf_core #(.CONV_CYC(TAB)) i_smf_core (.mclk_i(mclk_i), .srst_i(srst_i),
		.cfg_wr_i(cfg_wr_i), .cfg_wdata_i(cfg_wdata_i), .bus_rd_i(bus_rd_i),
		.shunt_sample_i(smp_w), .cfg_o(cfg_w), .shunt_drop_result_o(res),
		.conversion_ready_flag_o(rdy), .shunt_conv_active_o(sh_act),
		.bus_conv_active_o(bus_act), .shunt_sample_take_o(take));
	smf_adc_model i_smf_adc_model (.take_i(take), .value_i(val),
		.sample_o(smp_w));
	task automatic chk(input logic [20:0] seen, input logic [20:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic step();
		@(posedge mclk_i);
		#1;
	endtask
	task automatic wr(input logic [15:0] d);
		cfg_wdata_i = d;
		cfg_wr_i = 1'b1;
		step();
		cfg_wr_i = 1'b0;
	endtask
	// Stops the phases, then starts a continuous shunt run and times the take.
	task automatic conv(input int g, input logic [3:0] s, input logic [16:0] v);
		int n;
		val = v;
		wr(16'h0000);
		wr({3'h0, g[1:0], 4'h3, s, 3'h5});
		chk(cfg_w, {3'h0, g[1:0], 4'h3, s, 3'h5});
		chk(rdy, 1'b0);
		n = 1;
		while (take !== 1'b1 && n < 40)
		begin
			step();
			n++;
		end
		chk(21'(n), TAB[s]);
		step();
	endtask
	initial
	begin
		logic [15:0] keep;
		logic        xr;
		logic        sh;
		logic        bs;
		void'($urandom(21));
		repeat (12) @(posedge mclk_i);
		#1;
		srst_i = 1'b0;
		chk(cfg_w, 16'h399f);
		chk(res, 16'h0000);
		$display("test reset done");
		for (int g = 0; g < 4; g++)
		begin
			conv(g, 4'hf, 17'(4002 << g));
			chk(res, POS[g]);
			conv(g, 4'he, -17'(4001 << g));
			chk(res, NEG[g]);
			conv(g, 4'hd, 17'h1ffff);
			chk(res, 16'hffff);
			for (int k = 0; k < 5; k++)
			begin
				conv(g, 4'($urandom_range(15)),
					17'(int'($urandom_range(8 * (1000 << g) + 8)) - (4000 << g) - 4));
				chk(res, fmt(val, g));
			end
		end
		$display("test format done");
		xr = 1'b1;
		for (int m = 0; m < 8; m++)
		begin
			val = 17'($urandom_range(60000)) - 17'd30000;
			keep = res;
			wr({5'h03, 8'h00, m[2:0]});
			sh = 1'b0;
			bs = 1'b0;
			repeat (30)
			begin
				sh = sh | sh_act;
				bs = bs | bus_act;
				step();
			end
			chk(sh, m[0]);
			chk(bs, m[1]);
			chk(sh_act | bus_act, m[2] & (m[1:0] != 2'h0));
			chk(res, m[0] ? fmt(val, 3) : keep);
			xr = (m[1:0] != 2'h0) ? 1'b1 : xr;
			chk(rdy, xr);
			if (m == 3)
			begin
				bus_rd_i = 1'b1;
				step();
				bus_rd_i = 1'b0;
				chk(rdy, 1'b0);
				xr = 1'b0;
			end
		end
		$display("test modes done");
		wr(16'h8000);
		chk(cfg_w, 16'h399f);
		chk(sh_act, 1'b1);
		srst_i = 1'b1;
		repeat (2) step();
		srst_i = 1'b0;
		chk(cfg_w, 16'h399f);
		chk(res, 16'h0000);
		chk(rdy, 1'b0);
		$display("test restart done");
		give_verdict();
	end
	initial
	begin
		#(50 * 20000);
		n_mismatch++;
		give_verdict();
	end
endmodule
`default_nettype wire
